//--- rtl/tenbase_t_map.vh
// constants for the 10 Mbps twisted-pair link control block
`ifndef TENBASE_T_MAP_VH
`define TENBASE_T_MAP_VH
// clock rate in kHz (125 MHz)
`define CLK_KHZ          125000
// jabber limit in ms, within the 20 to 150 ms window
`define JABBER_MS        50
`define JABBER_CYC       (`JABBER_MS * `CLK_KHZ)
// unjab interval in ms, within the 250 to 750 ms window
`define UNJAB_MS         500
`define UNJAB_CYC        (`UNJAB_MS * `CLK_KHZ)
// clocks per 10 Mbps bit and per half bit
`define BIT_CYC          12
`define HALF_CYC         6
// packets needed before polarity locks
`define POL_LOCK_PKTS    2'h2
// fifo shape
`define FIFO_WIDTH       4
`define FIFO_DEPTH       16
`define FIFO_AW          4
// link states
`define LINK_FAIL        1'b0
`define LINK_PASS        1'b1
// management register 21 bit that disables jabber
`define JAB_DIS_BIT      12
`endif

//--- rtl/nibble_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module nibble_fifo #(
	parameter WIDTH = 4,
	parameter DEPTH = 16,
	parameter AW    = 4
)(
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// fill side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// drain side
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready,
	// housekeeping
	input  wire             flush
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];   // storage words
	reg [AW:0]      wr_q;              // write pointer with wrap bit
	reg [AW:0]      rd_q;              // read pointer with wrap bit
	wire            full;
	wire            empty;
	assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty     = (wr_q == rd_q);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem[rd_q[AW-1:0]];
	// storage write, no reset needed on data
	always @(posedge clk)
	begin
		if (in_valid && !full)
			mem[wr_q[AW-1:0]] <= in_data;
	end
	// pointer update
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end
		else if (flush)
		begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (in_valid && !full)
				wr_q <= wr_q + 1'b1;
			if (out_ready && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule // nibble_fifo
`default_nettype wire

//--- rtl/tenbase_t_link_control.v
// 10 Mbps twisted-pair link control: manchester path, link state, crs/col, jabber, polarity
// Behaviour
// - accept nibbles or serial, manchester encode them
// - manchester decode receive, present 4-bit nibbles
// - start link fail; pass only via negotiation
// - continuously watch receive pair for link pulses; here rx_link_pulse is only used to set polarity from the first pulse
// - link pass: qualified receive activity asserts crs
// - tx and rx together: assert col and crs
// - link fail holds crs and col low
// - jabber timeout disables data, link pulses resume once tx stops
// - jabber asserts col and sets status bit
// - unjab wait after tx stops, then recover
// - during jabber crs follows receive activity
// - register 21 bit 12 disables jabber
// - polarity from first link pulse, corrected early
// - lock polarity after two consecutive packets
// - synthesizer selects 20 MHz set after reset
`timescale 1ns/100ps
`default_nettype none
`include "tenbase_t_map.vh"
module tenbase_t_link_control #(
	parameter JABBER_CYCLES = `JABBER_CYC,  // shorten for simulation
	parameter UNJAB_CYCLES  = `UNJAB_CYC    // shorten for simulation
)(
	// clock and reset
	input  wire       clk,
	input  wire       rst,
	// mii transmit side
	input  wire [3:0] tx_nibble,
	input  wire       tx_nibble_valid,
	output reg        tx_nibble_ready,
	input  wire       serial_mode,
	input  wire       tx_serial_bit,
	input  wire       tx_en,
	// mii receive side
	output reg  [3:0] rx_nibble,
	output reg        rx_dv,
	output reg        crs,
	output reg        col,
	// line side, sliced receive and transmit levels
	input  wire       rx_line,
	input  wire       rx_qualified,
	input  wire       rx_link_pulse,
	input  wire       rx_pulse_neg,
	output reg        tx_line,
	output reg        tx_line_en,
	output reg        tx_link_pulse,
	input  wire       link_pulse_due,
	// negotiation and management
	input  wire       aneg_link_good,
	input  wire       jabber_disable,
	output reg        jabber_status,
	output reg        link_state,
	output reg        pol_inverted,
	output reg        pol_locked,
	output reg        clk_sel_20m,
	input  wire       sel_100m
);
	// ****************************************
	// shared functions
	// ****************************************
	// manchester half-bit value: first half is inverted data
	function manch;
		input d;
		input second_half;
		begin
			manch = second_half ? d : ~d;
		end
	endfunction

	// ****************************************
	// link state
	// ****************************************
	// link fail after reset, only negotiation moves to pass
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			link_state <= `LINK_FAIL;
		else
			case (link_state)
				`LINK_FAIL: if (aneg_link_good) link_state <= `LINK_PASS;
				`LINK_PASS: if (!aneg_link_good) link_state <= `LINK_FAIL;
				default:    link_state <= `LINK_FAIL;
			endcase
	end
	// clock set select follows speed choice
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			clk_sel_20m <= 1'b1;
		else
			clk_sel_20m <= ~sel_100m;
	end

	// ****************************************
	// transmit path
	// ****************************************
	wire [3:0] fifo_data;
	wire       fifo_valid;
	wire       fifo_pop;
	wire       fifo_in_ready;
	// 16-word fifo between mii nibbles and the serialiser
	nibble_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (tx_nibble),
		.in_valid  (tx_nibble_valid && !serial_mode),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.flush     (1'b0)
	);
	reg [3:0] half_cnt_q;     // clocks within a half bit
	reg       half_q;         // which half of the bit
	reg [1:0] bit_idx_q;      // bit within the nibble
	reg [3:0] sh_q;           // nibble being sent
	reg       sh_vld_q;       // nibble loaded
	reg       jab_q;          // jabber in effect
	wire      half_end = (half_cnt_q == `HALF_CYC - 1);
	wire      bit_end  = half_end && half_q;
	wire      cur_bit  = serial_mode ? tx_serial_bit : sh_q[bit_idx_q];
	wire      tx_act   = serial_mode ? tx_en : sh_vld_q;
	// pop when the serialiser is free or finishing its last bit
	assign fifo_pop = fifo_valid && !serial_mode && (!sh_vld_q || (bit_end && bit_idx_q == 2'h3));
	wire      tx_start = fifo_pop && !sh_vld_q;   // idle serialiser takes a fresh nibble
	// half-bit timing and nibble serialiser
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			half_cnt_q <= 4'h0;
			half_q     <= 1'b0;
			bit_idx_q  <= 2'h0;
			sh_q       <= 4'h0;
			sh_vld_q   <= 1'b0;
		end
		else
		begin
			// a fresh start restarts bit timing, else the first bit would be cut short
			half_cnt_q <= (half_end || tx_start) ? 4'h0 : half_cnt_q + 4'h1;
			if (tx_start)
				half_q <= 1'b0;
			else if (half_end)
				half_q <= ~half_q;
			if (fifo_pop)
			begin
				sh_q      <= fifo_data;
				sh_vld_q  <= 1'b1;
				bit_idx_q <= 2'h0;
			end
			else if (bit_end && sh_vld_q)
			begin
				bit_idx_q <= bit_idx_q + 2'h1;
				if (bit_idx_q == 2'h3)
					sh_vld_q <= 1'b0;
			end
		end
	end
	// line drive: data blocked under jabber, link pulses go out only while transmit is idle
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_line         <= 1'b0;
			tx_line_en      <= 1'b0;
			tx_link_pulse   <= 1'b0;
			tx_nibble_ready <= 1'b0;
		end
		else
		begin
			tx_line         <= manch(cur_bit, half_q) && tx_act && !jab_q;
			tx_line_en      <= tx_act && !jab_q;
			tx_link_pulse   <= link_pulse_due && !tx_act;
			tx_nibble_ready <= fifo_in_ready && !serial_mode;
		end
	end
	// ****************************************
	// jabber timer
	// ****************************************
	reg [31:0] jab_cnt_q;     // active time, then unjab time
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			jab_q         <= 1'b0;
			jab_cnt_q     <= 32'h0000_0000;
			jabber_status <= 1'b0;
		end
		else if (jabber_disable)
		begin
			jab_q     <= 1'b0;
			jab_cnt_q <= 32'h0000_0000;
		end
		else if (!jab_q)
		begin
			if (!tx_act)
				jab_cnt_q <= 32'h0000_0000;
			else if (jab_cnt_q >= JABBER_CYCLES - 1)
			begin
				jab_q         <= 1'b1;
				jabber_status <= 1'b1;
				jab_cnt_q     <= 32'h0000_0000;
			end
			else
				jab_cnt_q <= jab_cnt_q + 32'h0000_0001;
		end
		else
		begin
			// unjab time only runs while transmit stays quiet
			if (tx_act)
				jab_cnt_q <= 32'h0000_0000;
			else if (jab_cnt_q >= UNJAB_CYCLES - 1)
			begin
				jab_q     <= 1'b0;
				jab_cnt_q <= 32'h0000_0000;
			end
			else
				jab_cnt_q <= jab_cnt_q + 32'h0000_0001;
		end
	end

	// ****************************************
	// polarity detection and lock
	// ****************************************
	reg       pol_seen_q;     // first link pulse already judged
	reg [1:0] pkt_cnt_q;      // consecutive packets seen
	reg       rx_qual_q;      // delayed activity for end-of-packet
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pol_inverted <= 1'b0;
			pol_locked   <= 1'b0;
			pol_seen_q   <= 1'b0;
			pkt_cnt_q    <= 2'h0;
			rx_qual_q    <= 1'b0;
		end
		else
		begin
			rx_qual_q <= rx_qualified;
			// first link pulse sets polarity; a locked correction ignores pulses
			if (rx_link_pulse && !pol_seen_q && !pol_locked)
			begin
				pol_inverted <= rx_pulse_neg;
				pol_seen_q   <= 1'b1;
			end
			// fail drops the lock; leaving pass re-arms detection even if never locked
			if (link_state == `LINK_FAIL)
			begin
				pol_locked <= 1'b0;
				pkt_cnt_q  <= 2'h0;
			end
			else if (!aneg_link_good)
				pol_seen_q <= 1'b0;
			else if (!pol_locked && rx_qual_q && !rx_qualified)
			begin
				if (pkt_cnt_q == `POL_LOCK_PKTS - 2'h1)
					pol_locked <= 1'b1;
				pkt_cnt_q <= pkt_cnt_q + 2'h1;
			end
		end
	end

	// ****************************************
	// receive decode and deserialiser
	// ****************************************
	reg       rx_d_q;         // corrected previous line level
	reg [3:0] rx_cnt_q;       // clocks since last mid-bit transition
	reg [3:0] rx_sh_q;        // assembling nibble
	reg [1:0] rx_idx_q;       // bits collected
	wire      rx_corr = rx_line ^ pol_inverted;
	// mid-bit edge after at least 3/4 bit gives data, ignores boundary edges
	wire      mid_edge = rx_qualified && (rx_corr != rx_d_q) && (rx_cnt_q >= (`BIT_CYC * 3) / 4);
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_d_q    <= 1'b0;
			rx_cnt_q  <= 4'h0;
			rx_sh_q   <= 4'h0;
			rx_idx_q  <= 2'h0;
			rx_nibble <= 4'h0;
			rx_dv     <= 1'b0;
		end
		else
		begin
			rx_d_q <= rx_corr;
			rx_dv  <= 1'b0;
			if (!rx_qualified)
			begin
				rx_cnt_q <= 4'hf;
				rx_idx_q <= 2'h0;
			end
			else if (mid_edge)
			begin
				rx_cnt_q <= 4'h0;
				rx_sh_q[rx_idx_q] <= rx_corr;
				rx_idx_q <= rx_idx_q + 2'h1;
				if (rx_idx_q == 2'h3)
				begin
					rx_nibble <= {rx_corr, rx_sh_q[2:0]};
					rx_dv     <= link_state;
				end
			end
			else if (rx_cnt_q != 4'hf)
				rx_cnt_q <= rx_cnt_q + 4'h1;
		end
	end

	// ****************************************
	// carrier sense and collision
	// ****************************************
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			crs <= 1'b0;
			col <= 1'b0;
		end
		else if (link_state == `LINK_FAIL)
		begin
			crs <= 1'b0;
			col <= 1'b0;
		end
		else
		begin
			crs <= rx_qualified || (tx_act && rx_qualified);
			col <= jab_q || (tx_act && rx_qualified);
		end
	end
endmodule // tenbase_t_link_control
`default_nettype wire

//--- verif/tenbase_t_link_props.sv
// assertion checker for the 10 Mbps link control block
`timescale 1ns/100ps
`default_nettype none
module tenbase_t_link_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// inputs that cause things
	input wire logic rx_qualified,
	input wire logic serial_mode,
	input wire logic tx_en,
	input wire logic link_pulse_due,
	input wire logic aneg_link_good,
	input wire logic sel_100m,
	// watched outputs
	input wire logic crs,
	input wire logic col,
	input wire logic rx_dv,
	input wire logic jabber_status,
	input wire logic link_state,
	input wire logic pol_inverted,
	input wire logic pol_locked,
	input wire logic clk_sel_20m,
	input wire logic tx_link_pulse
);
	// ****************
	// properties
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// jabber onset while the link is up
	sequence s_jab_on;
		$rose(jabber_status) && link_state;
	endsequence
	// col must then hold, not just blip
	sequence s_col_held;
		##[0:1] col [*6];
	endsequence
	chk_fail_quiet: assert property (!link_state && !$past(link_state) |-> !crs && !col)
		else $error("crs or col high in link fail");
	chk_crs_follows: assert property (link_state && $past(link_state) |-> crs == $past(rx_qualified))
		else $error("crs does not follow receive activity");
	chk_jab_col: assert property (s_jab_on |-> s_col_held)
		else $error("jabber without col");
	chk_status_sticky: assert property ($past(jabber_status) |-> jabber_status)
		else $error("jabber status dropped");
	chk_pass_cause: assert property ($rose(link_state) |-> $past(aneg_link_good))
		else $error("link pass without negotiation");
	chk_lock_drop: assert property ($fell(link_state) |-> ##[0:1] !pol_locked)
		else $error("polarity lock kept in link fail");
	chk_pol_frozen: assert property (pol_locked && $past(pol_locked) |-> pol_inverted == $past(pol_inverted))
		else $error("polarity moved while locked");
	chk_clk_set: assert property (!$past(rst) |-> clk_sel_20m == !$past(sel_100m))
		else $error("clock set select wrong");
	chk_pulse_due: assert property (tx_link_pulse |-> $past(link_pulse_due))
		else $error("link pulse without request");
	chk_dv_single: assert property (rx_dv |=> !rx_dv)
		else $error("rx_dv longer than one cycle");
	// serial transmit and receive both active on an up link
	sequence s_both_active;
		$past(link_state) && $past(serial_mode && tx_en && rx_qualified);
	endsequence
	chk_col_both: assert property (s_both_active |-> col && crs)
		else $error("no collision on simultaneous activity");
	chk_dv_link: assert property (rx_dv |-> $past(link_state))
		else $error("rx_dv outside link pass");
endmodule // tenbase_t_link_props
bind tenbase_t_link_control tenbase_t_link_props tenbase_t_link_props_inst (.clk, .rst, .rx_qualified,
	.serial_mode, .tx_en,
	.link_pulse_due, .aneg_link_good, .sel_100m, .crs, .col, .rx_dv, .jabber_status, .link_state,
	.pol_inverted, .pol_locked, .clk_sel_20m, .tx_link_pulse);
`default_nettype wire

//--- verif/mii_mac_model.sv
// behavioural mac on the mii side: offers nibbles, keeps decoded ones
`timescale 1ns/100ps
`default_nettype none
module mii_mac_model (
	// clock
	input  wire logic       clk,
	// transmit offer
	output logic      [3:0] tx_nibble,
	output logic            tx_nibble_valid,
	input  wire logic       tx_nibble_ready,
	// receive nibbles
	input  wire logic [3:0] rx_nibble,
	input  wire logic       rx_dv
);
	logic [3:0] rx_last_q = 4'h0;	// last decoded nibble
	initial
	begin
		tx_nibble = 4'h0;
		tx_nibble_valid = 1'b0;
	end
	// dv is a one-cycle strobe, so sample every edge
	always @(posedge clk)
		if (rx_dv === 1'b1)
			rx_last_q <= rx_nibble;
	// gap makes a slow mac; offer holds until ready seen at a rising edge
	task automatic send(input logic [3:0] n, input int gap);
		repeat (gap) @(negedge clk);
		tx_nibble = n;
		tx_nibble_valid = 1'b1;
		@(posedge clk);
		while (tx_nibble_ready !== 1'b1)
			@(posedge clk);
		@(negedge clk);
		tx_nibble_valid = 1'b0;
		tx_nibble = ~n;	// stale data must not look valid
	endtask
endmodule // mii_mac_model
`default_nettype wire

//--- verif/tenbase_t_link_control_test.sv
// self-checking bench for the 10 Mbps link control block
`timescale 1ns/100ps
`default_nettype none
module tenbase_t_link_control_test;
	logic clk = 1'b0, rst = 1'b1, serial_mode = 1'b0, tx_serial_bit = 1'b0, tx_en = 1'b0;
	logic rx_line = 1'b0, rx_qualified = 1'b0, rx_link_pulse = 1'b0, rx_pulse_neg = 1'b0;
	logic link_pulse_due = 1'b0, aneg_link_good = 1'b0, jabber_disable = 1'b0, sel_100m = 1'b0;
	wire logic [3:0] tx_nibble, rx_nibble;
	wire logic tx_nibble_valid, tx_nibble_ready, rx_dv, crs, col, tx_line, tx_line_en;
	wire logic tx_link_pulse, jabber_status, link_state, pol_inverted, pol_locked, clk_sel_20m;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	// ****************
	// harness
	// ****************
	// short jabber and unjab counts keep the run brief
	tenbase_t_link_control #(.JABBER_CYCLES(200), .UNJAB_CYCLES(400)) tenbase_t_link_control_inst (.clk, .rst,
		.tx_nibble, .tx_nibble_valid, .tx_nibble_ready, .serial_mode, .tx_serial_bit, .tx_en, .rx_nibble,
		.rx_dv, .crs, .col, .rx_line, .rx_qualified, .rx_link_pulse, .rx_pulse_neg, .tx_line, .tx_line_en,
		.tx_link_pulse, .link_pulse_due, .aneg_link_good, .jabber_disable, .jabber_status, .link_state,
		.pol_inverted, .pol_locked, .clk_sel_20m, .sel_100m);
	mii_mac_model mii_mac_model_inst (.clk, .tx_nibble, .tx_nibble_valid, .tx_nibble_ready, .rx_nibble, .rx_dv);
	always #4 clk = ~clk;
	// hang guard, run needs about 1150 cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// manchester bits, first half inverted; inv models crossed pair wiring
	task automatic rx_send(input logic [3:0] n, input logic inv);
		// rest at the first half level so the first edge seen is a mid-bit one
		rx_line = ~n[0] ^ inv;
		tick(1);
		rx_qualified = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			rx_line = ~n[i] ^ inv;
			tick(6);
			rx_line = n[i] ^ inv;
			tick(6);
		end
		rx_qualified = 1'b0;
		rx_line = ~rx_line;
		tick(4);
		check(mii_mac_model_inst.rx_last_q, n);
	endtask
	// activity in link fail must stay hidden
	task automatic t_fail();
		check(clk_sel_20m, 1'b1);
		serial_mode = 1'b1;
		tx_en = 1'b1;
		rx_qualified = 1'b1;
		tick(20);
		check({link_state, crs, col}, 3'b000);
		tx_en = 1'b0;
		rx_qualified = 1'b0;
		$display("test fail done");
	endtask
	// polarity sense, correction, lock and release
	task automatic t_polarity();
		rx_pulse_neg = 1'b1;
		rx_link_pulse = 1'b1;
		tick(1);
		rx_link_pulse = 1'b0;
		aneg_link_good = 1'b1;
		tick(3);
		check({link_state, pol_inverted}, 2'b11);
		rx_send(4'h3, 1'b1);
		check(pol_locked, 1'b0);
		rx_send(4'hc, 1'b1);
		check(pol_locked, 1'b1);
		rx_pulse_neg = 1'b0;
		rx_link_pulse = 1'b1;
		tick(1);
		rx_link_pulse = 1'b0;
		aneg_link_good = 1'b0;
		tick(3);
		check({link_state, pol_locked, pol_inverted}, 3'b001);
		rx_link_pulse = 1'b1;
		tick(1);
		rx_link_pulse = 1'b0;
		aneg_link_good = 1'b1;
		tick(3);
		check(pol_inverted, 1'b0);
		rx_send(4'h9, 1'b0);
		$display("test polarity done");
	endtask
	// carrier, collision and idle link pulses
	task automatic t_crs_col();
		rx_qualified = 1'b1;
		tick(2);
		check({crs, col}, 2'b10);
		tx_en = 1'b1;
		tick(2);
		check({crs, col}, 2'b11);
		tx_en = 1'b0;
		rx_qualified = 1'b0;
		link_pulse_due = 1'b1;
		tick(2);
		check({crs, col, tx_link_pulse}, 3'b001);
		link_pulse_due = 1'b0;
		$display("test crs col done");
	endtask
	// one nibble, lsb first, each bit 12 clocks
	task automatic t_tx();
		int i;
		serial_mode = 1'b0;
		mii_mac_model_inst.send(4'h6, 2);
		for (i = 0; i < 40 && tx_line_en !== 1'b1; i++)
			tick(1);
		tick(3);
		for (i = 0; i < 4; i++)
		begin
			check(tx_line, ~4'h6 >> i & 1);
			tick(6);
			check(tx_line, 4'h6 >> i & 1);
			tick(6);
		end
		serial_mode = 1'b1;
		$display("test tx done");
	endtask
	// jabber, then unjab, then disabled jabber
	task automatic t_jabber();
		tx_en = 1'b1;
		tick(210);
		check({col, jabber_status, crs, tx_line_en}, 4'b1100);
		rx_qualified = 1'b1;
		tick(2);
		check({col, crs}, 2'b11);
		rx_qualified = 1'b0;
		tx_en = 1'b0;
		link_pulse_due = 1'b1;
		tick(2);
		check(tx_link_pulse, 1'b1);
		link_pulse_due = 1'b0;
		tick(350);
		check(col, 1'b1);
		tick(60);
		check(col, 1'b0);
		jabber_disable = 1'b1;
		tx_en = 1'b1;
		tick(250);
		check({col, tx_line_en}, 2'b01);
		tx_en = 1'b0;
		jabber_disable = 1'b0;
		sel_100m = 1'b1;
		tick(2);
		check(clk_sel_20m, 1'b0);
		rst = 1'b1;
		aneg_link_good = 1'b0;
		tick(2);
		rst = 1'b0;
		sel_100m = 1'b0;
		tick(2);
		check({jabber_status, link_state, clk_sel_20m}, 3'b001);
		$display("test jabber done");
	endtask
	initial
	begin
		tick(12);
		rst = 1'b0;
		tick(1);
		t_fail();
		t_polarity();
		t_crs_col();
		t_tx();
		t_jabber();
		final_report();
	end
endmodule // tenbase_t_link_control_test
`default_nettype wire
